// ### otp_guard_host.sv
// Host controller that seals, reads and queries the flash one-time area
// Summary of operation
// - Seal: A5, 00-00-01-00, then 10
// - Read: AF, two column, two page, 30
// - Each further page needs full sequence
// - Reset before pipelined read after one-time read
// - Keep write-protect steady during operations
// - First command after power-on is reset
// - Wait ready or 100us before reset
// - Track reset busy by line or status
// - Hold write-protect low while supply settles
`timescale 1ns/1ps
module otp_guard_host #(
	parameter int BUSY_LIMIT_CYC = otp_guard_pkg::BUSY_MAX_CYC, // Busy timeout in cycles
	parameter int DEPTH          = otp_guard_pkg::PAGE_BYTES    // Page buffer bytes
) (
	input  wire logic                            clk,        // 20 MHz clock
	input  wire logic                            arst_n,     // Async reset, low
	input  wire logic                            clkEn,      // Freezes all state when low
	input  wire logic                            cmdValid,   // Request valid
	input  wire logic [1:0]                      cmdOp,      // Operation code
	input  wire logic [otp_guard_pkg::COL_W-1:0] cmdCol,     // Start column
	input  wire logic [otp_guard_pkg::PAGE_W-1:0] cmdPage,   // One-time page
	input  wire logic [otp_guard_pkg::COL_W-1:0] cmdLen,     // Bytes to read
	output logic                                 cmdReady,   // Ready for request
	output logic                                 done,       // Operation finished pulse
	output logic                                 fail,       // Failed or timed out
	output logic                                 timeout,    // Busy line stuck low
	output logic                                 sealed,     // Area sealed, last status
	output logic [7:0]                           statusByte, // Last status byte
	output logic                                 initDone,   // Power-on reset finished
	input  wire logic [otp_guard_pkg::COL_W-1:0] rdAddr,     // Buffer read address
	output logic [7:0]                           rdData,     // Buffer read byte
	output logic                                 ceN,        // Chip enable, low
	output logic                                 cle,        // Command latch enable
	output logic                                 ale,        // Address latch enable
	output logic                                 weN,        // Write enable, low
	output logic                                 reN,        // Read enable, low
	output logic                                 wpN,        // Write protect, low
	output logic [7:0]                           ioOut,      // Bus byte driven
	input  wire logic [7:0]                      ioIn,       // Bus byte seen
	output logic                                 ioOeN,      // Bus drive, low = driving
	input  wire logic                            readyBusy   // ready_busy_line, high ready
);
	localparam int AW  = $clog2(DEPTH);
	localparam int CW  = $clog2(BUSY_LIMIT_CYC + 1);
	localparam int PCW = $clog2(otp_guard_pkg::POR_WAIT_CYC + 1);
	localparam logic [otp_guard_pkg::COL_W-1:0] COL_W_DEPTH = DEPTH[otp_guard_pkg::COL_W-1:0]; // Length clamp
	////////////////////////////////////////////////////////////////////////////////
	// Elaboration checks
	if (BUSY_LIMIT_CYC < 8 || DEPTH < 2 || DEPTH >= (1 << otp_guard_pkg::COL_W)) begin : g_chk
		$error("Unsupported BUSY_LIMIT_CYC or DEPTH");
	end
	typedef enum logic [3:0] {
		ST_POWER, ST_FETCH, ST_WRLO, ST_WRHI, ST_TWB, ST_BUSY,
		ST_WHR, ST_RDLO, ST_RDHI, ST_SETTLE, ST_IDLE
	} state_t;
	state_t                          state_r;             // Sequencer state
	otp_guard_pkg::op_t              op_r;                // Current operation
	logic [otp_guard_pkg::IDX_W-1:0] idx_r;               // Step index
	logic [CW-1:0]                   cnt_r;               // Phase counter
	logic [PCW-1:0]                  porCnt_r;            // Power-up wait counter
	logic                            porOk_r;             // Power-up wait satisfied
	logic [otp_guard_pkg::COL_W-1:0] col_r, len_r, rdCnt_r; // Column, length, bytes read
	logic [otp_guard_pkg::PAGE_W-1:0] page_r;             // Page index
	logic [2:0]                      addrCnt_r;           // Address cycles since command
	logic [1:0]                      rstSync_r;           // Reset release stages
	logic                            rstN;                // Synchronised reset
	logic                            rbS1_r, rbS2_r;      // Busy line synchroniser
	logic [7:0]                      ioS1_r, ioS2_r;      // Bus byte synchroniser
	logic                            cmdReady_r, done_r, fail_r, timeout_r, sealed_r, initDone_r;
	logic                            ceN_r, cle_r, ale_r, weN_r, reN_r, wpN_r, ioOeN_r;
	logic [7:0]                      ioOut_r, statusByte_r;
	otp_guard_pkg::step_t            step;                // Current step
	logic                            capture;             // Sample a read byte now
	otp_buf_if #(.AW(AW))            buf_bus ();           // Buffer link
	////////////////////////////////////////////////////////////////////////////////
	// Step table: each operation as a list of bus steps
	function automatic otp_guard_pkg::step_t seq_step(input otp_guard_pkg::op_t op,
		input logic [otp_guard_pkg::IDX_W-1:0] i, input logic [11:0] c, input logic [7:0] p);
		otp_guard_pkg::step_t s;
		s = '{otp_guard_pkg::K_END, 8'h00};
		unique case (op)
			otp_guard_pkg::OP_SEAL: begin
				unique case (i)
					4'h0: s = '{otp_guard_pkg::K_CMD, otp_guard_pkg::CMD_SEAL};
					4'h1: s = '{otp_guard_pkg::K_ADDR, otp_guard_pkg::SEAL_ADDR0};
					4'h2: s = '{otp_guard_pkg::K_ADDR, otp_guard_pkg::SEAL_ADDR1};
					4'h3: s = '{otp_guard_pkg::K_ADDR, otp_guard_pkg::SEAL_ADDR2};
					4'h4: s = '{otp_guard_pkg::K_ADDR, otp_guard_pkg::SEAL_ADDR3};
					4'h5: s = '{otp_guard_pkg::K_CMD, otp_guard_pkg::CMD_PROG_CONF};
					4'h6: s = '{otp_guard_pkg::K_WAIT, 8'h00};
					4'h7: s = '{otp_guard_pkg::K_CMD, otp_guard_pkg::CMD_STATUS};
					4'h8: s = '{otp_guard_pkg::K_STAT, 8'h00};
					default: s = '{otp_guard_pkg::K_END, 8'h00};
				endcase
			end
			otp_guard_pkg::OP_READ: begin
				unique case (i)
					4'h0: s = '{otp_guard_pkg::K_CMD, otp_guard_pkg::CMD_OTP_READ};
					4'h1: s = '{otp_guard_pkg::K_ADDR, c[7:0]};
					4'h2: s = '{otp_guard_pkg::K_ADDR, {4'h0, c[11:8]}};
					4'h3: s = '{otp_guard_pkg::K_ADDR, p};
					4'h4: s = '{otp_guard_pkg::K_ADDR, 8'h00};
					4'h5: s = '{otp_guard_pkg::K_CMD, otp_guard_pkg::CMD_READ_CONF};
					4'h6: s = '{otp_guard_pkg::K_WAIT, 8'h00};
					4'h7: s = '{otp_guard_pkg::K_DATA, 8'h00};
					4'h8: s = '{otp_guard_pkg::K_CMD, otp_guard_pkg::CMD_RESET};
					4'h9: s = '{otp_guard_pkg::K_WAIT, 8'h00};
					default: s = '{otp_guard_pkg::K_END, 8'h00};
				endcase
			end
			otp_guard_pkg::OP_STATUS: begin
				unique case (i)
					4'h0: s = '{otp_guard_pkg::K_CMD, otp_guard_pkg::CMD_STATUS};
					4'h1: s = '{otp_guard_pkg::K_STAT, 8'h00};
					default: s = '{otp_guard_pkg::K_END, 8'h00};
				endcase
			end
			otp_guard_pkg::OP_RESET: begin
				unique case (i)
					4'h0: s = '{otp_guard_pkg::K_CMD, otp_guard_pkg::CMD_RESET};
					4'h1: s = '{otp_guard_pkg::K_WAIT, 8'h00};
					default: s = '{otp_guard_pkg::K_END, 8'h00};
				endcase
			end
		endcase
		return s;
	endfunction
	// Phase counter reaches the last cycle of an n-cycle phase
	function automatic logic hit(input int n);
		return cnt_r == CW'(n - 1);
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	// Decoding
	assign step    = seq_step(op_r, idx_r, col_r, page_r);
	assign capture = (state_r == ST_RDHI) && (cnt_r == '0);
	assign buf_bus.en     = clkEn;
	assign buf_bus.wrEn   = clkEn && capture && (step.kind == otp_guard_pkg::K_DATA);
	assign buf_bus.wrAddr = rdCnt_r[AW-1:0];
	assign buf_bus.wrData = ioS2_r;
	assign buf_bus.rdAddr = rdAddr[AW-1:0];
	otp_page_buffer #(.DEPTH(DEPTH), .AW(AW)) u_buf (.clk(clk), .bus(buf_bus.mem));
	////////////////////////////////////////////////////////////////////////////////
	// Reset release and pin synchronisers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rstSync_r <= 2'h0;
		end else if (clkEn) begin
			rstSync_r <= {rstSync_r[0], 1'b1};
		end
	end
	assign rstN = rstSync_r[1];
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			{rbS1_r, rbS2_r, ioS1_r, ioS2_r} <= '0;
		end else if (clkEn) begin
			{rbS1_r, rbS2_r, ioS1_r, ioS2_r} <= {readyBusy, rbS1_r, ioIn, ioS1_r};
		end
	end
	// Power-up wait: ready seen or least time elapsed
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			porCnt_r <= '0;
			porOk_r  <= 1'b0;
		end else if (clkEn && !porOk_r) begin
			porCnt_r <= porCnt_r + PCW'(1);
			porOk_r  <= rbS2_r || (porCnt_r == PCW'(otp_guard_pkg::POR_WAIT_CYC - 1));
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Sequencer: walks the step table and drives the pins
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			state_r <= ST_POWER;  op_r <= otp_guard_pkg::OP_RESET;  idx_r <= '0;  cnt_r <= '0;
			{col_r, len_r, rdCnt_r, page_r, addrCnt_r} <= '0;
			{cmdReady_r, done_r, fail_r, timeout_r, sealed_r, initDone_r} <= '0;
			{ceN_r, weN_r, reN_r, ioOeN_r} <= 4'hF;
			{cle_r, ale_r, wpN_r} <= 3'h0; // Write protect held low from power-up
			ioOut_r <= 8'h00;  statusByte_r <= 8'h00;
		end else if (clkEn) begin
			done_r <= 1'b0;
			unique case (state_r)
				ST_POWER: if (porOk_r) begin // First command waits for the power-up gate
					ceN_r <= 1'b0;
					state_r <= ST_FETCH;
				end
				ST_IDLE: if (cmdValid && cmdReady_r) begin // One request per sequence
					cmdReady_r <= 1'b0;  ceN_r <= 1'b0;  op_r <= otp_guard_pkg::op_t'(cmdOp);
					col_r <= cmdCol;  page_r <= cmdPage;  idx_r <= '0;  rdCnt_r <= '0;
					len_r <= (cmdLen > COL_W_DEPTH) ? COL_W_DEPTH : cmdLen;
					fail_r <= 1'b0;  timeout_r <= 1'b0;
					state_r <= ST_FETCH;
				end
				ST_FETCH: unique case (step.kind)
					otp_guard_pkg::K_CMD, otp_guard_pkg::K_ADDR: begin // Start a write cycle
						cle_r <= (step.kind == otp_guard_pkg::K_CMD);
						ale_r <= (step.kind == otp_guard_pkg::K_ADDR);
						ioOut_r <= step.val;  ioOeN_r <= 1'b0;  weN_r <= 1'b0;
						state_r <= ST_WRLO;
					end
					otp_guard_pkg::K_WAIT: begin cnt_r <= '0; state_r <= ST_TWB; end
					otp_guard_pkg::K_STAT: begin cnt_r <= '0; state_r <= ST_WHR; end
					otp_guard_pkg::K_DATA: if (rdCnt_r == len_r) begin // All bytes taken
						idx_r <= idx_r + 4'h1;
					end else begin
						reN_r <= 1'b0;  cnt_r <= '0;  state_r <= ST_RDLO;
					end
					otp_guard_pkg::K_END: if (initDone_r) begin // Hand back to the user
						done_r <= 1'b1;  ceN_r <= 1'b1;  cmdReady_r <= 1'b1;  state_r <= ST_IDLE;
					end else begin // Release write protect, then allow setup time
						wpN_r <= 1'b1;  cnt_r <= '0;  state_r <= ST_SETTLE;
					end
					default: idx_r <= '1;
				endcase
				ST_WRLO: begin
					weN_r <= 1'b1;
					if (ale_r) addrCnt_r <= addrCnt_r + 3'h1;
					state_r <= ST_WRHI;
				end
				ST_WRHI: begin // Data held one cycle past the strobe
					if (cle_r) addrCnt_r <= 3'h0;
					{cle_r, ale_r, ioOeN_r} <= 3'b001;
					idx_r <= idx_r + 4'h1;  state_r <= ST_FETCH;
				end
				ST_TWB: begin // Let the busy line fall before watching it
					cnt_r <= cnt_r + CW'(1);
					if (hit(otp_guard_pkg::WB_CYC)) begin cnt_r <= '0; state_r <= ST_BUSY; end
				end
				ST_BUSY: begin // Wait for ready, bounded by the timeout
					cnt_r <= cnt_r + CW'(1);
					if (rbS2_r) begin
						idx_r <= idx_r + 4'h1;  state_r <= ST_FETCH;
					end else if (hit(BUSY_LIMIT_CYC)) begin
						timeout_r <= 1'b1;  fail_r <= 1'b1;  idx_r <= '1;  state_r <= ST_FETCH;
					end
				end
				ST_WHR: begin
					cnt_r <= cnt_r + CW'(1);
					if (hit(otp_guard_pkg::WHR_CYC)) begin reN_r <= 1'b0; cnt_r <= '0; state_r <= ST_RDLO; end
				end
				ST_RDLO: begin
					cnt_r <= cnt_r + CW'(1);
					if (hit(otp_guard_pkg::RE_LOW_CYC)) begin reN_r <= 1'b1; cnt_r <= '0; state_r <= ST_RDHI; end
				end
				ST_RDHI: begin
					cnt_r <= cnt_r + CW'(1);
					if (capture && step.kind == otp_guard_pkg::K_STAT) begin
						statusByte_r <= ioS2_r;
						fail_r <= ioS2_r[otp_guard_pkg::ST_FAIL_BIT];
						sealed_r <= !ioS2_r[otp_guard_pkg::ST_OPEN_BIT];
					end
					if (hit(otp_guard_pkg::RE_HIGH_CYC)) begin
						cnt_r <= '0;  state_r <= ST_FETCH;
						if (step.kind == otp_guard_pkg::K_STAT) idx_r <= idx_r + 4'h1;
						else rdCnt_r <= rdCnt_r + 12'h001;
					end
				end
				ST_SETTLE: begin // Write protect then stays high, untouched
					cnt_r <= cnt_r + CW'(1);
					if (hit(otp_guard_pkg::WW_CYC)) begin
						initDone_r <= 1'b1;  ceN_r <= 1'b1;  cmdReady_r <= 1'b1;  state_r <= ST_IDLE;
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Outputs straight from flip-flops
	assign {cmdReady, done, fail, timeout, sealed, initDone} =
		{cmdReady_r, done_r, fail_r, timeout_r, sealed_r, initDone_r};
	assign {ceN, cle, ale, weN, reN, wpN, ioOeN} = {ceN_r, cle_r, ale_r, weN_r, reN_r, wpN_r, ioOeN_r};
	assign ioOut      = ioOut_r;
	assign statusByte = statusByte_r;
	assign rdData     = buf_bus.rdData;
	////////////////////////////////////////////////////////////////////////////////
	// Checks
	chk_seal_addr4: assert property (@(posedge clk) disable iff (!rstN)
		($rose(weN_r) && cle_r && ioOut_r == otp_guard_pkg::CMD_PROG_CONF && op_r == otp_guard_pkg::OP_SEAL)
		|-> addrCnt_r == 3'h4) else $error("Seal confirm without four addresses");
	chk_read_addr4: assert property (@(posedge clk) disable iff (!rstN)
		($rose(weN_r) && cle_r && ioOut_r == otp_guard_pkg::CMD_READ_CONF) |-> addrCnt_r == 3'h4)
		else $error("Read confirm without four addresses");
	chk_wp_steady: assert property (@(posedge clk) disable iff (!rstN)
		(initDone_r && $past(initDone_r)) |-> (wpN_r && $stable(wpN_r))) else $error("Write protect moved");
	chk_wp_low_init: assert property (@(posedge clk) disable iff (!rstN)
		(state_r != ST_SETTLE && !initDone_r) |-> !wpN_r) else $error("Write protect high too early");
	chk_first_is_reset: assert property (@(posedge clk) disable iff (!rstN)
		(cle_r && !weN_r && !initDone_r) |-> ioOut_r == otp_guard_pkg::CMD_RESET)
		else $error("First command is not reset");
	chk_por_gate: assert property (@(posedge clk) disable iff (!rstN)
		($fell(weN_r) && !initDone_r) |-> porOk_r) else $error("Reset sent before power-up wait");
	chk_reset_after_read: assert property (@(posedge clk) disable iff (!rstN)
		(cle_r && !weN_r && op_r == otp_guard_pkg::OP_READ && idx_r > 4'h7 && state_r == ST_WRLO)
		|-> ioOut_r == otp_guard_pkg::CMD_RESET) else $error("No reset after one-time read");
	chk_read_strobe: assert property (@(posedge clk) disable iff (!rstN)
		(clkEn && $fell(reN_r)) |=> (!reN_r || !clkEn) ##1 (reN_r || !clkEn)) else $error("Read strobe length");
	chk_busy_quiet: assert property (@(posedge clk) disable iff (!rstN)
		(state_r == ST_BUSY) |-> (weN_r && reN_r && !ceN_r)) else $error("Strobe during busy");
	chk_one_request: assert property (@(posedge clk) disable iff (!rstN)
		(clkEn && cmdValid && cmdReady_r) |=> !cmdReady_r) else $error("Request taken twice");
	cov_seal: cover property (@(posedge clk) disable iff (!rstN) done_r && op_r == otp_guard_pkg::OP_SEAL);
	cov_read: cover property (@(posedge clk) disable iff (!rstN) done_r && op_r == otp_guard_pkg::OP_READ && rdCnt_r != 0);
	cov_init: cover property (@(posedge clk) disable iff (!rstN) $rose(initDone_r));
	cov_tmo:  cover property (@(posedge clk) disable iff (!rstN) $rose(timeout_r));
endmodule // otp_guard_host

// ### otp_guard_pkg.sv
// Constants, command codes and types shared by the one-time area controller
package otp_guard_pkg;
	////////////////////////////////////////////////////////////////////////////////
	// Timing, expressed in its own unit and converted to 50 ns clock cycles
	localparam int CLK_PERIOD_NS   = 50;                 // System clock period
	localparam int POR_WAIT_US     = 100;                // Least wait after supply before first reset
	localparam int POR_WAIT_CYC    = (POR_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BUSY_MAX_US     = 1000;               // Longest busy period (first reset)
	localparam int BUSY_MAX_CYC    = (BUSY_MAX_US * 1000) / CLK_PERIOD_NS;
	localparam int T_WB_NS         = 100;                // Write-enable high to busy valid
	localparam int WB_CYC          = (T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_WHR_NS        = 80;                 // Write-enable high to read-enable low
	localparam int WHR_CYC         = (T_WHR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_WW_NS         = 100;                // inhibit_setup_time before first user command
	localparam int WW_CYC          = (T_WW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RE_LOW_CYC      = 2;                  // Read strobe low phase
	localparam int RE_HIGH_CYC     = 2;                  // Read strobe high phase
	////////////////////////////////////////////////////////////////////////////////
	// Command and address codes
	localparam logic [7:0] CMD_SEAL      = 8'hA5;        // Seal the one-time area
	localparam logic [7:0] CMD_PROG_CONF = 8'h10;        // Seal confirmation
	localparam logic [7:0] CMD_OTP_READ  = 8'hAF;        // One-time area read
	localparam logic [7:0] CMD_READ_CONF = 8'h30;        // Read confirmation
	localparam logic [7:0] CMD_STATUS    = 8'h70;        // Status query
	localparam logic [7:0] CMD_RESET     = 8'hFF;        // Reset
	localparam logic [7:0] SEAL_ADDR0    = 8'h00;        // Seal address cycles, in order
	localparam logic [7:0] SEAL_ADDR1    = 8'h00;
	localparam logic [7:0] SEAL_ADDR2    = 8'h01;
	localparam logic [7:0] SEAL_ADDR3    = 8'h00;
	////////////////////////////////////////////////////////////////////////////////
	// Status byte fields
	localparam int ST_FAIL_BIT  = 0;                     // 1 = operation failed
	localparam int ST_ARRAY_BIT = 5;                     // Follows ready_busy_line
	localparam int ST_READY_BIT = 6;                     // Follows ready_busy_line
	localparam int ST_OPEN_BIT  = 7;                     // 0 = one-time area sealed
	////////////////////////////////////////////////////////////////////////////////
	// Sizes
	localparam int PAGE_BYTES = 2112;                    // One-time page size
	localparam int COL_W      = 12;                      // Column and length width
	localparam int PAGE_W     = 8;                       // One-time page index width
	localparam int IDX_W      = 4;                       // Step index width
	////////////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [1:0] {OP_SEAL, OP_READ, OP_STATUS, OP_RESET} op_t;
	typedef enum logic [2:0] {K_CMD, K_ADDR, K_WAIT, K_STAT, K_DATA, K_END} kind_t;
	typedef struct packed {
		kind_t       kind;                               // What the step does
		logic [7:0]  val;                                // Byte put on the bus
	} step_t;
endpackage

// ### otp_buf_if.sv
// Carrier between the controller and its page buffer
`timescale 1ns/1ps
interface otp_buf_if #(parameter int AW = 12);
	logic          en;                                   // Clock enable
	logic          wrEn;                                 // Write strobe
	logic [AW-1:0] wrAddr;                               // Write address
	logic [7:0]    wrData;                               // Write byte
	logic [AW-1:0] rdAddr;                               // Read address
	logic [7:0]    rdData;                               // Registered read byte
	modport writer (output en, wrEn, wrAddr, wrData, rdAddr, input rdData);
	modport mem    (input en, wrEn, wrAddr, wrData, rdAddr, output rdData);
endinterface

// ### otp_page_buffer.sv
// Byte memory holding the last one-time page read
`timescale 1ns/1ps
module otp_page_buffer #(
	parameter int DEPTH = otp_guard_pkg::PAGE_BYTES,      // Bytes held
	parameter int AW    = 12                              // Address width
) (
	input  wire logic   clk,                              // System clock
	otp_buf_if.mem      bus                               // Write and read port
);
	////////////////////////////////////////////////////////////////////////////////
	// Elaboration check
	if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_chk
		$error("DEPTH does not fit the address width");
	end
	logic [7:0] mem [DEPTH];                              // Storage
	logic [7:0] rdData_r;                                 // Read register
	// Write and registered read, frozen with the enable
	always_ff @(posedge clk) begin
		if (bus.en) begin
			if (bus.wrEn) begin
				mem[bus.wrAddr] <= bus.wrData;
			end
			rdData_r <= mem[bus.rdAddr];
		end
	end
	assign bus.rdData = rdData_r;
endmodule // otp_page_buffer

// ### otp_guard_host_fix_note_placeholder.sv
// Intentionally empty helper file holding no logic
`timescale 1ns/1ps

// ### otp_flash_model.sv
// Behavioural flash device answering the controller across the pins
`timescale 1ns/1ps
module otp_flash_model #(
	parameter int PU_NS    = 2000, // Power-up to ready
	parameter int SEAL_NS  = 3000, // Seal busy, like a page program
	parameter int FETCH_NS = 1000, // Page fetch busy
	parameter int RST_NS   = 500   // Reset busy
) (
	input  wire logic       ceN,      // Chip enable, low
	input  wire logic       cle,      // Command latch
	input  wire logic       ale,      // Address latch
	input  wire logic       weN,      // Write strobe, low
	input  wire logic       reN,      // Read strobe, low
	input  wire logic       wpN,      // Write protect, low
	input  wire logic [7:0] ioOut,    // Byte from controller
	input  wire logic       ioOeN,    // Controller drives, low
	output logic      [7:0] ioIn,     // Byte to controller
	output logic            readyBusy // ready_busy_line
);
	logic [7:0]  cmd, prv, dout, a [4]; // Commands, output byte, address cycles
	logic [2:0]  n;                     // Address cycle count
	logic [11:0] col;                   // Read column
	logic        isSealed, failBit, rdOn; // Seal state, result, bus driven
	wire  logic [7:0] stat = {~isSealed, readyBusy, readyBusy, 4'h0, failBit};
	// Released bus shows the inverse of the last byte
	assign ioIn = rdOn ? dout : ~dout;
	initial begin
		{isSealed, failBit, rdOn, n, cmd, prv, col, dout} = '0;
		readyBusy = 1'b0;
		#(PU_NS) readyBusy = 1'b1;
	end
	task automatic busy(input int t);
		readyBusy = 1'b0;
		#(t) readyBusy = 1'b1;
	endtask
	// Latches command and address cycles on the write strobe rise
	always @(posedge weN) if (!ceN && !ioOeN && ale) begin
		a[n] = ioOut;
		n = n + 3'h1;
	end else if (!ceN && !ioOeN && cle) begin
		prv = cmd;
		cmd = ioOut;
		n = (cmd == 8'h10 || cmd == 8'h30) ? n : 3'h0;
		if (cmd == 8'h10 && prv == 8'hA5) begin
			failBit = !(wpN && n == 3'h4 && a[0] == 8'h00 && a[1] == 8'h00 && a[2] == 8'h01 && a[3] == 8'h00);
			busy(isSealed ? 200 : SEAL_NS);
			isSealed = isSealed | !failBit;
		end else if (cmd == 8'h30 && prv == 8'hAF) begin
			col = {a[1][3:0], a[0]};
			busy(FETCH_NS);
		end else if (cmd == 8'hFF)
			busy(RST_NS);
	end
	// Drives status or page data while the read strobe is low
	always @(negedge reN) begin
		dout = (cmd == 8'h70) ? stat : (col[7:0] ^ {col[11:8], a[2][3:0]});
		rdOn = 1'b1;
	end
	always @(posedge reN) begin
		if (cmd != 8'h70) col = col + 12'h001;
		#75 rdOn = !reN;
	end
endmodule // otp_flash_model

// ### otp_guard_host_tb.sv
// Self-checking bench for the one-time area controller
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module otp_guard_host_tb;
	logic        clk = 1'b0, arst_n = 1'b0, cmdValid = 1'b0;          // Clock, reset, request
	logic [1:0]  cmdOp = 2'h0;                                       // Operation
	logic [11:0] cmdCol = 12'h000, cmdLen = 12'h000, rdAddr = 12'h000, c; // Column, length, address
	logic [7:0]  cmdPage = 8'h00, rdData, statusByte, ioOut, ioIn;   // Page and bytes
	logic        cmdReady, done, fail, timeout, sealed, initDone, ceN, cle, ale, weN, reN, wpN, ioOeN, readyBusy;
	int          n_errors = 0, checks = 0;                           // Mismatches and comparisons
	always #25 clk = ~clk;
	otp_guard_host #(.BUSY_LIMIT_CYC(200)) DUT (.clk, .arst_n, .clkEn(1'b1), .cmdValid, .cmdOp, .cmdCol, .cmdPage,
		.cmdLen, .cmdReady, .done, .fail, .timeout, .sealed, .statusByte, .initDone, .rdAddr, .rdData, .ceN,
		.cle, .ale, .weN, .reN, .wpN, .ioOut, .ioIn, .ioOeN, .readyBusy);
	otp_flash_model FLASH (.ceN, .cle, .ale, .weN, .reN, .wpN, .ioOut, .ioOeN, .ioIn, .readyBusy);
	task automatic end_of_test;
		if (n_errors == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// One request, held until taken, then a bounded wait for done
	task automatic run(input logic [1:0] o, input logic [7:0] p, input logic [11:0] cl, input logic [11:0] ln);
		int k;
		{cmdOp, cmdPage, cmdCol, cmdLen, cmdValid} = {o, p, cl, ln, 1'b1};
		while (cmdReady !== 1'b1) begin
			@(posedge clk);
			#1;
		end
		@(posedge clk);
		#1 cmdValid = 1'b0;
		for (k = 0; k < 9000 && done !== 1'b1; k++) begin
			@(posedge clk);
			#1;
		end
		`CHK(done, 1'b1)
	endtask
	// Reads a page and compares the buffered bytes with the device pattern
	task automatic rd(input logic [7:0] p, input logic [11:0] cl, input logic [11:0] ln);
		run(2'h1, p, cl, ln);
		for (int i = 0; i < ln; i++) begin
			rdAddr = 12'(i);
			repeat (2) @(posedge clk);
			#1 c = cl + 12'(i);
			`CHK(rdData, c[7:0] ^ {c[11:8], p[3:0]})
		end
	endtask
	initial begin
		#2000000 n_errors++;
		end_of_test;
	end
	initial begin
		repeat (12) @(posedge clk);
		#1 arst_n = 1'b1;
		while (initDone !== 1'b1) begin
			@(posedge clk);
			#1;
		end
		`CHK(wpN, 1'b1)
		run(2'h2, 8'h00, 12'h000, 12'h000); `CHK({sealed, statusByte[7:5]}, 4'b0111)
		rd(8'h03, 12'h1FE, 12'h004);
		run(2'h0, 8'h00, 12'h000, 12'h000); `CHK({fail, timeout, sealed}, 3'b001)
		rd(8'h05, 12'h010, 12'h002);
		run(2'h3, 8'h00, 12'h000, 12'h000); `CHK(fail, 1'b0)
		run(2'h2, 8'h00, 12'h000, 12'h000); `CHK({sealed, statusByte[0]}, 2'b10)
		end_of_test;
	end
endmodule // otp_guard_host_tb
